// ==== rtcu_pkg.sv ====
// Package for the clock register update block: offsets, fields, timing
package rtcu_pkg;

  // ---------------------------------------------------------------
  // Bus and register map
  // ---------------------------------------------------------------
  localparam int          ADDR_W        = 17;
  localparam logic [16:0] OFS_FLAG      = 17'h1FFF0;
  localparam logic [16:0] OFS_CENTURY   = 17'h1FFF1;
  localparam logic [16:0] OFS_AL_SEC    = 17'h1FFF2;
  localparam logic [16:0] OFS_AL_MIN    = 17'h1FFF3;
  localparam logic [16:0] OFS_AL_HOUR   = 17'h1FFF4;
  localparam logic [16:0] OFS_ALARM_DATE_REPEAT   = 17'h1FFF5;
  localparam logic [16:0] OFS_AL_MONTH  = 17'h1FFF6;
  localparam logic [16:0] OFS_WATCHDOG  = 17'h1FFF7;
  localparam logic [16:0] OFS_CONTROL   = 17'h1FFF8;
  localparam logic [16:0] OFS_SECONDS   = 17'h1FFF9;
  localparam logic [16:0] OFS_MINUTES   = 17'h1FFFA;
  localparam logic [16:0] OFS_HOURS     = 17'h1FFFB;
  localparam logic [16:0] OFS_WEEKDAY   = 17'h1FFFC;
  localparam logic [16:0] OFS_DATE      = 17'h1FFFD;
  localparam logic [16:0] OFS_MONTH     = 17'h1FFFE;
  localparam logic [16:0] OFS_YEAR      = 17'h1FFFF;
  localparam logic [12:0] CLK_PAGE      = 13'h1FFF;

  // ---------------------------------------------------------------
  // Field positions and masks
  // ---------------------------------------------------------------
  localparam int          BIT_LOAD      = 7;
  localparam int          BIT_FREEZE    = 6;
  localparam int          BIT_HALT      = 7;
  localparam int          BIT_TONE      = 6;
  localparam int          BIT_TOF       = 7;
  localparam int          BIT_AHF       = 6;
  localparam int          BIT_BLOW      = 4;
  localparam logic [7:0]  MASK_SEC      = 8'h7F;
  localparam logic [7:0]  MASK_MIN      = 8'h7F;
  localparam logic [7:0]  MASK_HOUR     = 8'h3F;
  localparam logic [7:0]  MASK_WDAY     = 8'h07;
  localparam logic [7:0]  MASK_DATE     = 8'h3F;
  localparam logic [7:0]  MASK_MONTH    = 8'h1F;
  localparam logic [7:0]  MASK_ALMON    = 8'hBF;
  localparam logic [7:0]  BCD_00        = 8'h00;
  localparam logic [7:0]  BCD_01        = 8'h01;
  localparam logic [7:0]  BCD_02        = 8'h02;
  localparam logic [7:0]  BCD_04        = 8'h04;
  localparam logic [7:0]  BCD_06        = 8'h06;
  localparam logic [7:0]  BCD_09        = 8'h09;
  localparam logic [7:0]  BCD_11        = 8'h11;
  localparam logic [7:0]  BCD_07        = 8'h07;
  localparam logic [7:0]  BCD_12        = 8'h12;
  localparam logic [7:0]  BCD_23        = 8'h23;
  localparam logic [7:0]  BCD_28        = 8'h28;
  localparam logic [7:0]  BCD_29        = 8'h29;
  localparam logic [7:0]  BCD_30        = 8'h30;
  localparam logic [7:0]  BCD_31        = 8'h31;
  localparam logic [7:0]  BCD_59        = 8'h59;
  localparam logic [7:0]  BCD_99        = 8'h99;
  localparam logic [3:0]  NIB_9         = 4'h9;
  localparam logic [3:0]  NIB_0         = 4'h0;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLOCK_HZ     = 100_000_000;
  localparam int SECOND_S     = 1;
  localparam int SECOND_CYC   = CLOCK_HZ * SECOND_S;
  localparam int CAL_STEP_CYC = 64;

  // Time of day in packed BCD
  typedef struct packed {
    logic [7:0] century;
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] date;
    logic [7:0] weekday;
    logic [7:0] hours;
    logic [7:0] minutes;
    logic [7:0] seconds;
  } rtcu_time_t;

  // Byte bus pins seen by the device
  typedef struct packed {
    logic [16:0] addr;
    logic [7:0]  data;
    logic        chip_sel_n;
    logic        out_en_n;
    logic        write_n;
  } rtcu_bus_t;

endpackage

// ==== rtcu_core.sv ====
// Clock register set with visible copies, internal counters and byte bus
`timescale 1ns/100ps
`default_nettype none

module rtcu_core
  import rtcu_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // Asynchronous byte bus pins
  input  wire logic [16:0] addr,
  input  wire logic [7:0]  data_in,
  output logic      [7:0]  data_out,
  output logic             data_oe_n,
  input  wire logic        chip_sel_n,
  input  wire logic        out_en_n,
  input  wire logic        write_n,
  // Supply monitor and status pins
  input  wire logic        power_fail,
  input  wire logic        battery_low,
  input  wire logic        timeout_event,
  input  wire logic        alarm_event,
  // Register field outputs for neighbouring logic
  output logic             test_tone_enable,
  output logic             osc_halt,
  output logic             timeout_output_select,
  output logic      [4:0]  timeout_multiplier,
  output logic      [1:0]  timeout_resolution,
  output logic             alarm_pin_enable,
  output logic             alarm_on_battery_enable,
  output logic      [4:0]  alarm_repeat_bits,
  output logic             cal_speed_up,
  output logic      [4:0]  cal_magnitude,
  output logic             second_tick
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------

  // Packed BCD increment; caller handles wrap
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    logic [7:0] r;
    r = v;
    if (v[3:0] == NIB_9)
      r = {v[7:4] + 4'h1, NIB_0};
    else
      r = {v[7:4], v[3:0] + 4'h1};
    return r;
  endfunction

  // Last date of month, leap every fourth year (good until 2100)
  function automatic logic [7:0] month_end(input logic [7:0] mon, input logic [7:0] yr);
    logic [7:0] r;
    logic       leap;
    // Ten years is two modulo four, so an odd tens digit adds two
    leap = ((yr[4] ? 4'h2 : 4'h0) + yr[3:0]) % 4'h4 == 4'h0;
    r    = BCD_31;
    if (mon == BCD_02)
      r = leap ? BCD_29 : BCD_28;
    else if (mon == BCD_04 || mon == BCD_06 || mon == BCD_09 || mon == BCD_11)
      r = BCD_30;
    return r;
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum {ST_RUN, ST_FROZEN} rtcu_view_t;

  typedef struct packed {
    rtcu_bus_t   bus_s1;      // First synchroniser stage
    rtcu_bus_t   bus_s2;      // Second synchroniser stage
    logic [1:0]  pf_sync;     // Power fail synchroniser
    logic [1:0]  bl_sync;     // Battery low synchroniser
    logic [1:0]  to_sync;     // Timeout event synchroniser
    logic [1:0]  ah_sync;     // Alarm event synchroniser
    logic        wr_prev;     // Write active last cycle
    logic        rd_prev;     // Flag read active last cycle
    logic        float_hold;  // Access began as a write
    rtcu_time_t  counter;     // Internal counters
    rtcu_time_t  visible;     // User copy
    logic [7:0]  control;     // Load, freeze, calibration
    logic [7:0]  watchdog;    // Watchdog setting
    logic [7:0]  al_sec;      // Alarm second plus repeat
    logic [7:0]  al_min;
    logic [7:0]  al_hour;
    logic [7:0]  alarm_date_repeat;
    logic [7:0]  al_month;
    logic        halt;        // Oscillator stop
    logic        tone;        // Frequency test enable
    logic        timeout_flag;
    logic        alarm_hit_flag;
    logic [31:0] prescale;    // Cycles toward one second
    logic        tick;
    rtcu_view_t  view;
    logic [7:0]  dout;
  } rtcu_state_t;

  rtcu_state_t st;         // Registered state
  rtcu_state_t next_st;    // Next state

  // Bus decode on synchronised pins
  logic        sel;
  logic        wr_act;
  logic        rd_act;
  logic        pf;
  logic [7:0]  wdat;
  logic [16:0] wadr;
  logic [7:0]  rdat;
  logic [31:0] sec_len;

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    // Two flops on every pin before any use
    // Strobes and data share one sample, so a write never tears
    next_st.bus_s1  = '{addr, data_in, chip_sel_n, out_en_n, write_n};
    next_st.bus_s2  = st.bus_s1;
    next_st.pf_sync = {st.pf_sync[0], power_fail};
    next_st.bl_sync = {st.bl_sync[0], battery_low};
    next_st.to_sync = {st.to_sync[0], timeout_event};
    next_st.ah_sync = {st.ah_sync[0], alarm_event};
    next_st.tick    = 1'b0;

    pf = st.pf_sync[1];
    sel    = !pf && !st.bus_s2.chip_sel_n;
    wr_act = sel && !st.bus_s2.write_n;
    rd_act = sel && st.bus_s2.write_n && !st.bus_s2.out_en_n;
    wdat   = st.bus_s2.data;
    wadr   = st.bus_s2.addr;
    next_st.wr_prev = wr_act;
    next_st.rd_prev = rd_act && wadr == OFS_FLAG;

    // write start floats whole access
    // Held until deselect, so a late write rise cannot glitch drive
    if (!sel)
      next_st.float_hold = 1'b0;
    else if (wr_act)
      next_st.float_hold = 1'b1;

    // Trims every second by a fixed step: coarser than per-minute
    // blanking, but needs no minute counter
    // sign sets second length
    sec_len = SECOND_CYC;
    if (st.control[5])
      sec_len = SECOND_CYC - CAL_STEP_CYC * 32'(st.control[4:0]);
    else
      sec_len = SECOND_CYC + CAL_STEP_CYC * 32'(st.control[4:0]);

    // halt stops counting; restart at fresh second
    if (st.halt)
      next_st.prescale = '0;
    else if (st.prescale >= sec_len - 32'd1)
    begin
      next_st.prescale = '0;
      next_st.tick     = 1'b1;
    end
    else
      next_st.prescale = st.prescale + 32'd1;

    if (st.tick)
    begin
      next_st.counter.seconds = bcd_inc(st.counter.seconds);
      if (st.counter.seconds == BCD_59)
      begin
        next_st.counter.seconds = BCD_00;
        next_st.counter.minutes = bcd_inc(st.counter.minutes);
        if (st.counter.minutes == BCD_59)
        begin
          next_st.counter.minutes = BCD_00;
          next_st.counter.hours   = bcd_inc(st.counter.hours);
          if (st.counter.hours == BCD_23)
          begin
            next_st.counter.hours   = BCD_00;
            next_st.counter.weekday = (st.counter.weekday == BCD_07) ? BCD_01
                                      : bcd_inc(st.counter.weekday);
            next_st.counter.date    = bcd_inc(st.counter.date);
            if (st.counter.date == month_end(st.counter.month, st.counter.year))
            begin
              next_st.counter.date  = BCD_01;
              next_st.counter.month = bcd_inc(st.counter.month);
              if (st.counter.month == BCD_12)
              begin
                next_st.counter.month = BCD_01;
                next_st.counter.year  = bcd_inc(st.counter.year);
                if (st.counter.year == BCD_99)
                begin
                  next_st.counter.year    = BCD_00;
                  next_st.counter.century = bcd_inc(st.counter.century);
                end
              end
            end
          end
        end
      end
    end

    // simultaneous refresh of all visible copies
    // a refresh this cycle lands before freeze
    // unfrozen copy waits for next second tick
    // frozen copy keeps the time of the request
    if (st.tick && st.view == ST_RUN)
      next_st.visible = next_st.counter;

    next_st.view = (st.control[BIT_LOAD] || st.control[BIT_FREEZE]) ? ST_FROZEN : ST_RUN;

    // Register writes, applied on every cycle the synchronised write strobe is active
    // only the addressed byte is written
    if (wr_act && {wadr[16:4]} == CLK_PAGE)
    begin
      unique case (wadr)
        OFS_CENTURY:  next_st.visible.century = wdat;
        OFS_AL_SEC:   next_st.al_sec   = wdat;
        OFS_AL_MIN:   next_st.al_min   = wdat;
        OFS_AL_HOUR:  next_st.al_hour  = wdat;
        OFS_ALARM_DATE_REPEAT:  next_st.alarm_date_repeat  = wdat;
        OFS_AL_MONTH: next_st.al_month = wdat & MASK_ALMON;
        OFS_WATCHDOG: next_st.watchdog = wdat;
        OFS_CONTROL:  next_st.control  = wdat;
        OFS_SECONDS:
        begin
          next_st.visible.seconds = wdat & MASK_SEC;
          next_st.halt = wdat[BIT_HALT];
        end
        OFS_MINUTES:  next_st.visible.minutes = wdat & MASK_MIN;
        OFS_HOURS:    next_st.visible.hours   = wdat & MASK_HOUR;
        OFS_WEEKDAY:
        begin
          next_st.visible.weekday = wdat & MASK_WDAY;
          next_st.tone = wdat[BIT_TONE];
        end
        OFS_DATE:     next_st.visible.date  = wdat & MASK_DATE;
        OFS_MONTH:    next_st.visible.month = wdat & MASK_MONTH;
        OFS_YEAR:     next_st.visible.year  = wdat;
        default:      next_st.control = st.control;
      endcase
    end

    // load release copies visible into counters
    // Prescaler restarts so the next refresh is a full second away
    if (st.control[BIT_LOAD] && !next_st.control[BIT_LOAD])
    begin
      next_st.counter  = next_st.visible;
      next_st.prescale = '0;
    end

    // flag read clears timeout, set wins
    // Clearing at read end keeps the flag steady for the whole read
    if (st.rd_prev && !(rd_act && wadr == OFS_FLAG))
      next_st.timeout_flag = 1'b0;
    if (st.to_sync[1])
      next_st.timeout_flag = 1'b1;
    if (st.ah_sync[1])
      next_st.alarm_hit_flag = 1'b1;

    // power fail clears load and freeze
    // Cleared after the load release test, so a fail never copies
    if (pf)
    begin
      next_st.control[BIT_LOAD]   = 1'b0;
      next_st.control[BIT_FREEZE] = 1'b0;
    end

    // Read mux, registered onto pins
    // Registered so the pins never show decode glitches
    rdat = 8'h00;
    unique case (wadr)
      OFS_FLAG:     rdat = {st.timeout_flag, st.alarm_hit_flag, 1'b0, st.bl_sync[1], 4'h0};
      OFS_CENTURY:  rdat = st.visible.century;
      OFS_AL_SEC:   rdat = st.al_sec;
      OFS_AL_MIN:   rdat = st.al_min;
      OFS_AL_HOUR:  rdat = st.al_hour;
      OFS_ALARM_DATE_REPEAT:  rdat = st.alarm_date_repeat;
      OFS_AL_MONTH: rdat = st.al_month;
      OFS_WATCHDOG: rdat = st.watchdog;
      OFS_CONTROL:  rdat = st.control;
      OFS_SECONDS:  rdat = {st.halt, st.visible.seconds[6:0]};
      OFS_MINUTES:  rdat = st.visible.minutes;
      OFS_HOURS:    rdat = st.visible.hours;
      OFS_WEEKDAY:  rdat = {1'b0, st.tone, st.visible.weekday[5:0]};
      OFS_DATE:     rdat = st.visible.date;
      OFS_MONTH:    rdat = st.visible.month;
      OFS_YEAR:     rdat = st.visible.year;
      default:      rdat = 8'h00;
    endcase
    next_st.dout = rdat;
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      st                 <= '0;
      st.bus_s1          <= '{17'h00000, 8'h00, 1'b1, 1'b1, 1'b1};
      st.bus_s2          <= '{17'h00000, 8'h00, 1'b1, 1'b1, 1'b1};
      st.counter.month   <= BCD_01;
      st.counter.date    <= BCD_01;
      st.counter.weekday <= BCD_01;
      st.visible.month   <= BCD_01;
      st.visible.date    <= BCD_01;
      st.visible.weekday <= BCD_01;
      st.view            <= ST_RUN;
    end
    else
      st <= next_st;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // float unless a clean read
  // Drives one cycle before data_out settles, as an SRAM before its access time
  assign data_oe_n = !(!st.pf_sync[1] && !st.bus_s2.chip_sel_n
                       && !st.bus_s2.out_en_n && st.bus_s2.write_n && !st.float_hold);
  assign data_out                = st.dout;
  assign test_tone_enable        = st.tone;
  assign osc_halt                = st.halt;
  assign timeout_output_select   = st.watchdog[7];
  assign timeout_multiplier      = st.watchdog[6:2];
  assign timeout_resolution      = st.watchdog[1:0];
  assign alarm_pin_enable        = st.al_month[7];
  assign alarm_on_battery_enable = st.al_month[5];
  assign alarm_repeat_bits       = {st.alarm_date_repeat[6], st.alarm_date_repeat[7], st.al_hour[7],
                                    st.al_min[7], st.al_sec[7]};
  assign cal_speed_up            = st.control[5];
  assign cal_magnitude           = st.control[4:0];
  assign second_tick             = st.tick;

endmodule

`default_nettype wire

// ==== rtcu_host.sv ====
// Host processor model driving the asynchronous byte bus of the clock registers
`timescale 1ns/100ps
`default_nettype none
module rtcu_host
  import rtcu_pkg::*;
(
  // Clock
  input  wire logic       clock,
  // Pins toward the device
  output var rtcu_bus_t   bus,
  // Read return
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe_n
);
  // Bus idle at time zero, all strobes high
  initial
  begin
    bus = '{addr: 17'h00000, data: 8'h00, chip_sel_n: 1'b1, out_en_n: 1'b1, write_n: 1'b1};
  end

  // Release strobes; data flips so a stale byte never looks held
  task automatic idle();
    bus.chip_sel_n = 1'b1;
    bus.out_en_n   = 1'b1;
    bus.write_n    = 1'b1;
    bus.data       = ~bus.data;
    repeat (4) @(negedge clock);
  endtask

  task automatic write_byte(input logic [16:0] a, input logic [7:0] d);
    @(negedge clock);
    bus.addr       = a;
    bus.data       = d;
    bus.chip_sel_n = 1'b0;
    bus.write_n    = 1'b0;
    repeat (5) @(negedge clock);
    idle();
  endtask

  // Read held five clocks, sampled before release
  task automatic read_byte(input logic [16:0] a, output logic [7:0] d, output logic oe_n);
    @(negedge clock);
    bus.addr       = a;
    bus.chip_sel_n = 1'b0;
    bus.out_en_n   = 1'b0;
    repeat (5) @(negedge clock);
    // A floated bus reads as the inverse of the last byte
    d    = data_oe_n ? ~data_out : data_out;
    oe_n = data_oe_n;
    idle();
  endtask
endmodule
`default_nettype wire

// ==== rtcu_core_assertions.sv ====
// Pin-level assertions for the clock register update block
`timescale 1ns/100ps
`default_nettype none
module rtcu_core_assertions
  import rtcu_pkg::*;
(
  // Clock and reset
  input wire logic        clock,
  input wire logic        reset_n,
  // Bus pins
  input wire logic [16:0] addr,
  input wire logic [7:0]  data_in,
  input wire logic        data_oe_n,
  input wire logic        chip_sel_n,
  input wire logic        out_en_n,
  input wire logic        write_n,
  input wire logic        power_fail,
  // Register fields
  input wire logic        test_tone_enable,
  input wire logic        osc_halt,
  input wire logic        timeout_output_select,
  input wire logic [4:0]  timeout_multiplier,
  input wire logic [1:0]  timeout_resolution,
  input wire logic        alarm_pin_enable,
  input wire logic        alarm_on_battery_enable,
  input wire logic        cal_speed_up,
  input wire logic [4:0]  cal_magnitude
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  // Write strobes with good supply; five held cycles let the pin flops settle
  logic wr_on;
  assign wr_on = !chip_sel_n && !write_n && !power_fail;

  AST_PF_FLOAT: assert property (power_fail [*4] |-> data_oe_n)
    else $error("outputs driven during supply fail");
  AST_PF_HOLD: assert property (power_fail [*8] |-> $stable({cal_magnitude, osc_halt}))
    else $error("register changed during supply fail");
  AST_SIM_FALL: assert property ($fell(chip_sel_n) && $fell(write_n) |-> data_oe_n [*8])
    else $error("outputs driven after joint select and write fall");
  AST_READ_DRIVE: assert property ((!chip_sel_n && !out_en_n && write_n && !power_fail) [*4]
    |-> !data_oe_n)
    else $error("read not answered");
  AST_HALT: assert property ((wr_on && addr == OFS_SECONDS) [*5] |-> osc_halt == data_in[7])
    else $error("halt bit not taken");
  AST_TONE: assert property ((wr_on && addr == OFS_WEEKDAY) [*5]
    |-> test_tone_enable == data_in[6])
    else $error("tone bit not taken");
  AST_WDOG: assert property ((wr_on && addr == OFS_WATCHDOG) [*5]
    |-> {timeout_output_select, timeout_multiplier, timeout_resolution} == data_in)
    else $error("watchdog fields wrong");
  AST_CAL: assert property ((wr_on && addr == OFS_CONTROL) [*5]
    |-> {cal_speed_up, cal_magnitude} == data_in[5:0])
    else $error("calibration fields wrong");
  AST_ALMON: assert property ((wr_on && addr == OFS_AL_MONTH) [*5]
    |-> alarm_pin_enable == data_in[7] && alarm_on_battery_enable == data_in[5])
    else $error("alarm enables wrong");
endmodule

bind rtcu_core rtcu_core_assertions i_rtcu_core_assertions (.clock, .reset_n, .addr, .data_in,
  .data_oe_n, .chip_sel_n, .out_en_n, .write_n, .power_fail, .test_tone_enable, .osc_halt,
  .timeout_output_select, .timeout_multiplier, .timeout_resolution, .alarm_pin_enable,
  .alarm_on_battery_enable, .cal_speed_up, .cal_magnitude);
`default_nettype wire

// ==== rtcu_register_update_control_test.sv ====
// Self-checking testbench for the clock register update block
`timescale 1ns/100ps
`default_nettype none
module rtc_register_update_control_test
  import rtcu_pkg::*;
;
  // ---------------------------------------------------------------
  // Signals and model state
  // ---------------------------------------------------------------
  logic        clock;
  logic        reset_n;
  rtcu_bus_t   bus;
  logic [7:0]  data_out;
  logic        data_oe_n;
  logic        power_fail;
  logic        battery_low;
  logic        timeout_event;
  logic        alarm_event;
  logic        test_tone_enable;
  logic        osc_halt;
  logic        timeout_output_select;
  logic [4:0]  timeout_multiplier;
  logic [1:0]  timeout_resolution;
  logic        alarm_pin_enable;
  logic        alarm_on_battery_enable;
  logic [4:0]  alarm_repeat_bits;
  logic        cal_speed_up;
  logic [4:0]  cal_magnitude;
  logic        second_tick;
  int          ticks_seen = 0;
  logic [7:0]  rd_data;
  logic        rd_oe_n;
  int          miscompares = 0;
  int          samples_checked = 0;
  int          seed = 32'h6FA5;
  logic        exp_tof = 1'b0;
  logic        exp_ahf = 1'b0;
  // Expected bytes; reset time is 00 on 01-01, weekday 01
  int          exp_reg [16] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 1, 1, 1, 0};
  // Legal BCD range and free upper bits per register
  int          lo [16] = '{0, 0, 0, 0, 0, 1, 1, 0, 0, 0, 0, 0, 1, 1, 1, 0};
  int          hi [16] = '{0, 99, 59, 59, 23, 31, 12, 0, 0, 59, 59, 23, 7, 31, 12, 99};
  int          top [16] = '{0, 0, 8'h80, 8'h80, 8'h80, 8'hC0, 8'hA0, 8'hFF, 8'hFF, 8'h80,
                            0, 0, 8'h40, 0, 0, 0};

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  rtcu_core i_rtcu_core (.clock, .reset_n, .addr(bus.addr), .data_in(bus.data), .data_out,
    .data_oe_n, .chip_sel_n(bus.chip_sel_n), .out_en_n(bus.out_en_n), .write_n(bus.write_n),
    .power_fail, .battery_low, .timeout_event, .alarm_event, .test_tone_enable, .osc_halt,
    .timeout_output_select, .timeout_multiplier, .timeout_resolution, .alarm_pin_enable,
    .alarm_on_battery_enable, .alarm_repeat_bits, .cal_speed_up, .cal_magnitude,
    .second_tick);
  rtcu_host i_rtcu_host (.clock, .bus, .data_out, .data_oe_n);

  // Counted seconds; the run is far shorter than the shortest trimmed second
  always @(posedge clock)
    if (reset_n && second_tick === 1'b1)
      ticks_seen++;

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      miscompares++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  function automatic logic [7:0] to_bcd(input int n);
    return 8'((n / 10) * 16 + n % 10);
  endfunction

  // Write; the model drops it while supply is bad or the byte is read only
  task automatic wr(input int i, input logic [7:0] d);
    i_rtcu_host.write_byte({CLK_PAGE, 4'(i)}, d);
    if (!power_fail && i != 0)
      exp_reg[i] = d;
  endtask

  // Read and compare; a flag read clears the timeout flag
  task automatic rd_chk(input int i);
    logic [7:0] want;
    want = (i == 0) ? {exp_tof, exp_ahf, 1'b0, battery_low, 4'h0} : 8'(exp_reg[i]);
    i_rtcu_host.read_byte({CLK_PAGE, 4'(i)}, rd_data, rd_oe_n);
    check({7'h00, rd_oe_n}, {7'h00, power_fail});
    if (!power_fail)
      check(rd_data, want);
    if (i == 0 && !power_fail)
      exp_tof = 1'b0;
  endtask

  task automatic check_fields();
    check({7'h00, osc_halt}, {7'h00, exp_reg[9][7]});
    check({7'h00, test_tone_enable}, {7'h00, exp_reg[12][6]});
    check({timeout_output_select, timeout_multiplier, timeout_resolution}, 8'(exp_reg[7]));
    check({2'h0, cal_speed_up, cal_magnitude}, {2'h0, exp_reg[8][5:0]});
    check({6'h00, alarm_pin_enable, alarm_on_battery_enable},
          {6'h00, exp_reg[6][7], exp_reg[6][5]});
    check({3'h0, alarm_repeat_bits}, {3'h0, exp_reg[5][6], exp_reg[5][7], exp_reg[4][7],
          exp_reg[3][7], exp_reg[2][7]});
  endtask

  task automatic test_done();
    $display("checked %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Watchdog: the whole sequence needs well under 50 us
  initial
  begin
    #200_000;
    miscompares++;
    test_done();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    reset_n       = 1'b0;
    power_fail    = 1'b0;
    battery_low   = 1'b0;
    timeout_event = 1'b0;
    alarm_event   = 1'b0;
    repeat (10) @(negedge clock);
    reset_n = 1'b1;
    for (int i = 0; i < 16; i++)
      rd_chk(i);
    check_fields();
    $display("reset values done");
    // Random legal values, frozen before the read-back
    repeat (6)
    begin
      for (int i = 1; i < 16; i++)
        wr(i, to_bcd(lo[i] + {$random(seed)} % (hi[i] - lo[i] + 1))
              | (8'($random(seed)) & 8'(top[i])));
      check_fields();
      wr(8, (8'(exp_reg[8]) & 8'h3F) | 8'h40);
      for (int i = 1; i < 16; i++)
        rd_chk(i);
      wr(8, 8'(exp_reg[8]) & 8'h3F);
    end
    $display("register traffic done");
    // Sticky flags, read-only flag byte
    battery_low   = 1'b1;
    timeout_event = 1'b1;
    alarm_event   = 1'b1;
    repeat (4) @(negedge clock);
    timeout_event = 1'b0;
    alarm_event   = 1'b0;
    exp_tof       = 1'b1;
    exp_ahf       = 1'b1;
    wr(0, 8'($random(seed)));
    rd_chk(0);
    battery_low = 1'b0;
    repeat (4) @(negedge clock);
    rd_chk(0);
    $display("flag test done");
    // Address outside the clock page reads zero
    wr(1, 8'h42);
    i_rtcu_host.write_byte(17'({$random(seed)} % 32'h1FFF0), 8'hA5);
    i_rtcu_host.read_byte(17'h0ABCD, rd_data, rd_oe_n);
    check(rd_data, 8'h00);
    rd_chk(1);
    $display("unmapped test done");
    // Supply fail while loading: writes blocked, bits cleared
    wr(8, 8'hC5);
    power_fail  = 1'b1;
    exp_reg[8] &= 8'h3F;
    wr(7, 8'h5A);
    rd_chk(7);
    power_fail = 1'b0;
    repeat (4) @(negedge clock);
    rd_chk(8);
    rd_chk(7);
    check_fields();
    check(8'(ticks_seen), 8'h00);
    $display("supply fail test done");
    test_done();
  end
endmodule
`default_nettype wire
